// ==== src/ccc_clock_control.sv ====
`timescale 1ns/100ps
`include "ccc_clock_map.svh"
// Behaviour
// - source select chooses master clock or loop
// - invert bit complements master clock input
// - divide bit halves selected source
// - core clock gated by enable, reset off
// - enabled without master clock blocks access
// - clock rates two always accessible
// - fs select field, reset 101
// - one sample rate for both paths
// - ratio field codes 64 to 1536
// - decoder derives all divider settings
// - dac double oversample bit, reset 0
// - dsp clock gated from core clock
// - adc oversample bit, reset high
module ccc_clock_control (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic mclk_in,
  input wire logic fll_clock_in,
  input ccc_pkg::ccc_bus_req_t bus_req_in,
  output logic [15:0] rdata_out,
  output logic access_fail_out,
  output logic core_clock_out,
  output logic dsp_clock_out,
  output logic mclk_present_out,
  output logic [2:0] sample_rate_out,
  output logic fs_strobe_out,
  output logic adc_mod_strobe_out,
  output logic dac_mod_strobe_out
);
  import ccc_pkg::*;

  ccc_config_t cfg;
  ccc_gate_t gate_core;
  ccc_gate_t gate_dsp;
  ccc_gate_t next_gate_core;
  ccc_gate_t next_gate_dsp;
  logic src;
  logic src_prev;
  logic src_rise;
  logic level;
  logic next_level;
  logic mclk_prev;
  logic [7:0] idle_count;
  logic blocked;
  logic reg_hit;
  logic dsp_tick;
  logic [10:0] fs_divisor;
  logic [10:0] divisors [3];
  logic [2:0] strobes;

  // ----------------------------------------
  // master clock presence
  // ----------------------------------------
  // a stopped master clock is judged after a fixed idle time
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mclk_prev <= 1'b0;
      idle_count <= 8'h00;
    end else begin
      mclk_prev <= mclk_in;
      if (mclk_in != mclk_prev) begin
        idle_count <= 8'h00;
      end else if (idle_count < 8'(`CCC_MCLK_TIMEOUT_CYCLES)) begin
        idle_count <= idle_count + 8'h01;
      end
    end
  end

  assign mclk_present_out = idle_count < 8'(`CCC_MCLK_TIMEOUT_CYCLES);
  assign blocked = cfg.core_enable && !mclk_present_out;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  always_comb begin
    reg_hit = 1'b1;
    unique case (bus_req_in.addr)
      `CCC_ADDR_ADC_ANALOG_ZERO: reg_hit = 1'b1;
      `CCC_ADDR_RATES_ZERO: reg_hit = 1'b1;
      `CCC_ADDR_RATES_ONE: reg_hit = 1'b1;
      `CCC_ADDR_RATES_TWO: reg_hit = 1'b1;
      `CCC_ADDR_DAC_DIGITAL_ONE: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      cfg.mclk_invert <= `CCC_RST_OFF;
      cfg.source_select <= `CCC_RST_OFF;
      cfg.core_enable <= `CCC_RST_OFF;
      cfg.dsp_enable <= `CCC_RST_OFF;
      cfg.mclk_halve <= `CCC_RST_OFF;
      cfg.ratio <= `CCC_RST_RATIO;
      cfg.fs_select <= `CCC_RST_FS;
      cfg.dac_double <= `CCC_RST_OFF;
      cfg.adc_high <= `CCC_RST_ADC_HIGH_OSR;
    end else if (bus_req_in.write) begin
      if (bus_req_in.addr == `CCC_ADDR_RATES_TWO) begin
        cfg.mclk_invert <= bus_req_in.wdata[`CCC_BIT_MCLK_INVERT];
        cfg.source_select <= bus_req_in.wdata[`CCC_BIT_SOURCE_SELECT];
        cfg.core_enable <= bus_req_in.wdata[`CCC_BIT_CORE_ENABLE];
        cfg.dsp_enable <= bus_req_in.wdata[`CCC_BIT_DSP_ENABLE];
      end else if (!blocked) begin
        unique case (bus_req_in.addr)
          `CCC_ADDR_ADC_ANALOG_ZERO: cfg.adc_high <= bus_req_in.wdata[`CCC_BIT_ADC_HIGH_OSR];
          `CCC_ADDR_RATES_ZERO: cfg.mclk_halve <= bus_req_in.wdata[`CCC_BIT_MCLK_HALVE];
          `CCC_ADDR_RATES_ONE: begin
            cfg.ratio <= bus_req_in.wdata[`CCC_RATIO_MSB:`CCC_RATIO_LSB];
            cfg.fs_select <= bus_req_in.wdata[`CCC_FS_MSB:`CCC_FS_LSB];
          end
          `CCC_ADDR_DAC_DIGITAL_ONE: cfg.dac_double <= bus_req_in.wdata[`CCC_BIT_DAC_DOUBLE_OSR];
          default: ;
        endcase
      end
    end
  end

  // blocked reads return zero; unmapped offsets read zero and do not fail
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_out <= 16'h0000;
      access_fail_out <= 1'b0;
    end else begin
      rdata_out <= 16'h0000;
      access_fail_out <= (bus_req_in.write || bus_req_in.read) && reg_hit && blocked
        && bus_req_in.addr != `CCC_ADDR_RATES_TWO;
      if (bus_req_in.read && (!blocked || bus_req_in.addr == `CCC_ADDR_RATES_TWO)) begin
        unique case (bus_req_in.addr)
          `CCC_ADDR_ADC_ANALOG_ZERO: rdata_out[`CCC_BIT_ADC_HIGH_OSR] <= cfg.adc_high;
          `CCC_ADDR_RATES_ZERO: rdata_out[`CCC_BIT_MCLK_HALVE] <= cfg.mclk_halve;
          `CCC_ADDR_RATES_ONE: begin
            rdata_out[`CCC_RATIO_MSB:`CCC_RATIO_LSB] <= cfg.ratio;
            rdata_out[`CCC_FS_MSB:`CCC_FS_LSB] <= cfg.fs_select;
          end
          `CCC_ADDR_RATES_TWO: begin
            rdata_out[`CCC_BIT_MCLK_INVERT] <= cfg.mclk_invert;
            rdata_out[`CCC_BIT_SOURCE_SELECT] <= cfg.source_select;
            rdata_out[`CCC_BIT_CORE_ENABLE] <= cfg.core_enable;
            rdata_out[`CCC_BIT_DSP_ENABLE] <= cfg.dsp_enable;
          end
          `CCC_ADDR_DAC_DIGITAL_ONE: rdata_out[`CCC_BIT_DAC_DOUBLE_OSR] <= cfg.dac_double;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // source, invert, halve
  // ----------------------------------------
  assign src = cfg.source_select ? fll_clock_in : (mclk_in ^ cfg.mclk_invert);
  assign src_rise = src && !src_prev;
  assign next_level = cfg.mclk_halve ? (src_rise ? !level : level) : src;

  // ----------------------------------------
  // glitch-free gates
  // ----------------------------------------
  // gate state only moves while the clock is low, so no pulse is ever cut short
  always_comb begin
    next_gate_core = gate_core;
    next_gate_dsp = gate_dsp;
    if (!next_level) begin
      next_gate_core = cfg.core_enable ? CCC_GATE_ON : CCC_GATE_OFF;
      next_gate_dsp = (cfg.core_enable && cfg.dsp_enable) ? CCC_GATE_ON : CCC_GATE_OFF;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      src_prev <= 1'b0;
      level <= 1'b0;
      gate_core <= CCC_GATE_OFF;
      gate_dsp <= CCC_GATE_OFF;
      core_clock_out <= 1'b0;
      dsp_clock_out <= 1'b0;
    end else begin
      src_prev <= src;
      level <= next_level;
      gate_core <= next_gate_core;
      gate_dsp <= next_gate_dsp;
      core_clock_out <= next_level && next_gate_core == CCC_GATE_ON;
      dsp_clock_out <= next_level && next_gate_dsp == CCC_GATE_ON;
    end
  end

  // ----------------------------------------
  // sample rate decoder
  // ----------------------------------------
  function automatic logic [10:0] ratio_cycles(input logic [3:0] code);
    unique case (code)
      4'h0: ratio_cycles = 11'd64;
      4'h1: ratio_cycles = 11'd128;
      4'h2: ratio_cycles = 11'd192;
      4'h3: ratio_cycles = 11'd256;
      4'h4: ratio_cycles = 11'd384;
      4'h5: ratio_cycles = 11'd512;
      4'h6: ratio_cycles = 11'd768;
      4'h7: ratio_cycles = 11'd1024;
      4'h8: ratio_cycles = 11'd1408;
      4'h9: ratio_cycles = 11'd1536;
      default: ratio_cycles = 11'd256;
    endcase
  endfunction

  // one fs for both converters; modulator rates derived, never programmed
  assign sample_rate_out = cfg.fs_select;
  assign fs_divisor = ratio_cycles(cfg.ratio);
  assign divisors[0] = fs_divisor;
  assign divisors[1] = fs_divisor >> (cfg.adc_high ? `CCC_OSR_HIGH_SHIFT : `CCC_OSR_LOW_SHIFT);
  assign divisors[2] = fs_divisor >> (cfg.dac_double ? `CCC_OSR_HIGH_SHIFT : `CCC_OSR_LOW_SHIFT);
  assign dsp_tick = next_level && !level && next_gate_dsp == CCC_GATE_ON;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_div
      ccc_strobe_div u_div (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .tick_in(dsp_tick),
        .divisor_in(divisors[gi]),
        .strobe_out(strobes[gi])
      );
    end
  endgenerate

  assign fs_strobe_out = strobes[0];
  assign adc_mod_strobe_out = strobes[1];
  assign dac_mod_strobe_out = strobes[2];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  a_core_gate_off: assert property (gate_core == CCC_GATE_OFF |-> !core_clock_out)
    else $error("core clock running while gate off");
  a_no_runt_fall: assert property ($fell(core_clock_out) |-> !level)
    else $error("core clock cut while high");
  a_dsp_under_core: assert property (dsp_clock_out |-> core_clock_out)
    else $error("dsp clock without core clock");
  // level is held in reset, so the first edge after release has nothing to follow
  a_loop_source: assert property (!$past(reset_in)
    && $past(!cfg.mclk_halve && cfg.source_select) |-> level == $past(fll_clock_in))
    else $error("loop source not followed");
  a_mclk_invert: assert property (!$past(reset_in) && $past(!cfg.mclk_halve && !cfg.source_select)
    |-> level == $past(mclk_in ^ cfg.mclk_invert))
    else $error("master clock polarity wrong");
  a_halve_hold: assert property ($past(cfg.mclk_halve) && !$past(src_rise) |-> $stable(level))
    else $error("halved clock moved without source edge");
  a_halve_toggle: assert property ($past(cfg.mclk_halve) && $past(src_rise) |-> level != $past(level))
    else $error("halved clock missed a source edge");
  a_blocked_fail: assert property ((bus_req_in.write || bus_req_in.read) && blocked
    && bus_req_in.addr == `CCC_ADDR_RATES_ONE |=> access_fail_out && rdata_out == 16'h0000)
    else $error("blocked access not refused");
  a_blocked_hold: assert property (bus_req_in.write && blocked
    && bus_req_in.addr == `CCC_ADDR_RATES_ONE |=> $stable(cfg.ratio))
    else $error("blocked write changed ratio");
  a_fail_when_blocked: assert property (access_fail_out |-> $past(blocked))
    else $error("access refused while not blocked");
  a_unmapped_quiet: assert property ((bus_req_in.write || bus_req_in.read) && !reg_hit
    |=> !access_fail_out && rdata_out == 16'h0000)
    else $error("unmapped access answered");
  a_rates_two_open: assert property (bus_req_in.write && bus_req_in.addr == `CCC_ADDR_RATES_TWO
    |=> cfg.core_enable == $past(bus_req_in.wdata[`CCC_BIT_CORE_ENABLE]) && !access_fail_out)
    else $error("enable register write lost");
  a_rates_two_read: assert property (bus_req_in.read && bus_req_in.addr == `CCC_ADDR_RATES_TWO
    |=> !access_fail_out && rdata_out[`CCC_BIT_CORE_ENABLE] == $past(cfg.core_enable))
    else $error("enable register read refused");
  a_reset_values: assert property ($past(reset_in) |-> cfg.fs_select == `CCC_RST_FS
    && cfg.ratio == `CCC_RST_RATIO && cfg.adc_high && !cfg.dac_double)
    else $error("clock fields reset wrong");
  a_core_enable_off: assert property (!cfg.core_enable && !next_level |=> gate_core == CCC_GATE_OFF)
    else $error("core gate stayed on after disable");
  a_dsp_enable_off: assert property (!cfg.dsp_enable && !next_level |=> gate_dsp == CCC_GATE_OFF)
    else $error("dsp gate stayed on after disable");
  a_gate_core_hold: assert property ($changed(gate_core) |-> !$past(next_level))
    else $error("core gate moved with clock high");
  a_gate_dsp_hold: assert property ($changed(gate_dsp) |-> !$past(next_level))
    else $error("dsp gate moved with clock high");
  a_dsp_gate_off: assert property (gate_dsp == CCC_GATE_OFF |-> !dsp_clock_out)
    else $error("dsp clock running while gate off");
  a_ratio_top: assert property (cfg.ratio == 4'h9 |-> fs_divisor == 11'h600)
    else $error("top ratio code decoded wrong");

  // ----------------------------------------
  // scenario covers
  // ----------------------------------------
  c_fs_strobe: cover property (fs_strobe_out);
  c_blocked_access: cover property (access_fail_out);
  c_halved_running: cover property (cfg.mclk_halve && $rose(core_clock_out));
  c_dsp_running: cover property ($rose(dsp_clock_out));
  c_loop_running: cover property (cfg.source_select && $rose(core_clock_out));
endmodule

// ==== src/ccc_clock_map.svh ====
`ifndef CCC_CLOCK_MAP_SVH
`define CCC_CLOCK_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCC_ADDR_ADC_ANALOG_ZERO 8'h0a
`define CCC_ADDR_RATES_ZERO 8'h14
`define CCC_ADDR_RATES_ONE 8'h15
`define CCC_ADDR_RATES_TWO 8'h16
`define CCC_ADDR_DAC_DIGITAL_ONE 8'h21

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCC_BIT_MCLK_INVERT 15
`define CCC_BIT_SOURCE_SELECT 14
`define CCC_BIT_CORE_ENABLE 2
`define CCC_BIT_DSP_ENABLE 1
`define CCC_BIT_MCLK_HALVE 0
`define CCC_BIT_ADC_HIGH_OSR 0
`define CCC_BIT_DAC_DOUBLE_OSR 6
`define CCC_RATIO_MSB 13
`define CCC_RATIO_LSB 10
`define CCC_FS_MSB 2
`define CCC_FS_LSB 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCC_RST_RATIO 4'h3
`define CCC_RST_FS 3'h5
`define CCC_RST_ADC_HIGH_OSR 1'b1
`define CCC_RST_OFF 1'b0

// ----------------------------------------
// timing
// ----------------------------------------
`define CCC_CLOCK_PERIOD_NS 20
`define CCC_MCLK_TIMEOUT_NS 2000
`define CCC_MCLK_TIMEOUT_CYCLES (`CCC_MCLK_TIMEOUT_NS / `CCC_CLOCK_PERIOD_NS)
`define CCC_OSR_LOW_SHIFT 6
`define CCC_OSR_HIGH_SHIFT 7

`endif

// ==== src/ccc_pkg.sv ====
package ccc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic write;
    logic read;
  } ccc_bus_req_t;

  typedef struct packed {
    logic mclk_invert;
    logic source_select;
    logic core_enable;
    logic dsp_enable;
    logic mclk_halve;
    logic [3:0] ratio;
    logic [2:0] fs_select;
    logic dac_double;
    logic adc_high;
  } ccc_config_t;

  typedef enum logic {CCC_GATE_OFF, CCC_GATE_ON} ccc_gate_t;

endpackage

// ==== src/ccc_strobe_div.sv ====
`timescale 1ns/100ps
// one-cycle strobe every divisor_in ticks; divisor zero behaves as one
module ccc_strobe_div (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic [10:0] divisor_in,
  output logic strobe_out
);
  logic [10:0] count;
  logic [10:0] next_count;

  assign next_count = count + 11'h001;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      count <= 11'h000;
      strobe_out <= 1'b0;
    end else if (tick_in) begin
      if (next_count >= divisor_in) begin
        count <= 11'h000;
        strobe_out <= 1'b1;
      end else begin
        count <= next_count;
        strobe_out <= 1'b0;
      end
    end else begin
      strobe_out <= 1'b0;
    end
  end
endmodule

// ==== tb/ccc_mclk_src.sv ====
`timescale 1ns/100ps
// external master clock; stands still at its last level while stopped
module ccc_mclk_src #(
  parameter int HALF = 2
) (
  input wire logic clock_in,
  input wire logic run_in,
  output logic mclk_out
);
  int cnt;
  initial begin
    cnt = 0;
    mclk_out = 1'b0;
  end
  // period of 4 cycles: 12.5 MHz undivided, 6.25 MHz halved
  always @(posedge clock_in) begin
    if (run_in) begin
      cnt <= (cnt + 1) % HALF;
      if (cnt == HALF - 1) mclk_out <= ~mclk_out;
    end
  end
endmodule

// ==== tb/ccc_clock_control_tb_top.sv ====
`timescale 1ns/100ps
module ccc_clock_control_tb_top;
  import ccc_pkg::*;
  logic clock_in, reset_in, run, freq_locked_loop, mclk;
  logic fail, core, dsp, pres, fs_s, adc_s, dac_s;
  logic [2:0] fc, rate;
  logic [15:0] rdata;
  ccc_bus_req_t req;
  int n_errors, check_count, a, b, c;
  logic [7:0] ad [6] = '{8'h0a, 8'h14, 8'h15, 8'h16, 8'h21, 8'h30};
  logic [15:0] rv [6] = '{16'h0001, 16'h0000, 16'h0c05, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] wv [6] = '{16'h0001, 16'h0001, 16'h3c07, 16'hc006, 16'h0040, 16'h0000};
  logic [15:0] m2 [6] = '{16'h0004, 16'h0006, 16'h0002, 16'h0006, 16'h4006, 16'h8006};
  logic hv [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  int ec [6] = '{16, 16, 0, 8, 8, 16};
  int ed [6] = '{0, 16, 0, 8, 8, 16};
  int rt [10] = '{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536};

  ccc_mclk_src src (.clock_in(clock_in), .run_in(run), .mclk_out(mclk));

  ccc_clock_control uut (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .mclk_in(mclk),
    .fll_clock_in(freq_locked_loop),
    .bus_req_in(req),
    .rdata_out(rdata),
    .access_fail_out(fail),
    .core_clock_out(core),
    .dsp_clock_out(dsp),
    .mclk_present_out(pres),
    .sample_rate_out(rate),
    .fs_strobe_out(fs_s),
    .adc_mod_strobe_out(adc_s),
    .dac_mod_strobe_out(dac_s)
  );

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // loop output stand-in, period of 8 cycles
  always @(posedge clock_in) fc <= fc + 3'h1;
  assign freq_locked_loop = fc[2];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  // edge counts drift by one with the phase of the window
  task near(input int g, input int e);
    check_count++;
    if (g < e - 1 || g > e + 1) begin
      n_errors++;
      $display("BAD %0t count %0d want %0d", $time, g, e);
    end
  endtask

  task acc(input logic w, input logic [7:0] ad_i, input logic [15:0] d, input logic [15:0] e, input logic f);
    @(posedge clock_in);
    req <= '{ad_i, d, w, ~w};
    @(posedge clock_in);
    req <= '{ad_i, d, 1'b0, 1'b0};
    #1;
    chk(rdata, w ? 16'h0 : e);
    chk({15'h0, fail}, {15'h0, f});
  endtask

  task edges(input logic inv, input logic ph, output int nc, output int nd);
    logic pc, pd, pm;
    #1;
    nc = 0;
    nd = 0;
    pc = core;
    pd = dsp;
    pm = mclk;
    repeat (64) begin
      @(posedge clock_in);
      #1;
      nc += int'(core && !pc);
      nd += int'(dsp && !pd);
      if (ph) chk({15'h0, core}, {15'h0, pm ^ inv});
      pc = core;
      pd = dsp;
      pm = mclk;
    end
  endtask

  task gap(input int s, input int e);
    int n, k, t0;
    logic v;
    k = 0;
    t0 = 0;
    for (n = 0; n < 14000 && k < 2; n++) begin
      @(posedge clock_in);
      #1;
      v = (s == 0) ? fs_s : (s == 1) ? adc_s : dac_s;
      if (v === 1'b1) begin
        if (k == 1) chk(16'(n - t0), 16'(e));
        t0 = n;
        k++;
      end
    end
    if (k < 2) begin
      n_errors++;
      $display("BAD %0t no strobe", $time);
      end_sim();
    end
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    reset_in = 1'b1;
    run = 1'b1;
    fc = 3'h0;
    req = '0;
    n_errors = 0;
    check_count = 0;
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    for (c = 0; c < 6; c++) acc(1'b0, ad[c], 16'h0, rv[c], 1'b0);
    chk({13'h0, rate}, 16'h0005);
    for (c = 0; c < 6; c++) acc(1'b1, ad[c], 16'hffff, 16'h0, 1'b0);
    for (c = 0; c < 6; c++) acc(1'b0, ad[c], 16'h0, wv[c], 1'b0);
    chk({13'h0, rate}, 16'h0007);
    acc(1'b1, 8'h16, 16'h0, 16'h0, 1'b0);
    acc(1'b1, 8'h14, 16'h0, 16'h0, 1'b0);
    acc(1'b1, 8'h21, 16'h0, 16'h0, 1'b0);
    for (c = 0; c < 6; c++) begin
      acc(1'b1, 8'h15, 16'h0c00 | 16'(c), 16'h0, 1'b0);
      chk({13'h0, rate}, 16'(c));
    end
    $display("register test done");
    for (c = 0; c < 6; c++) begin
      acc(1'b1, 8'h16, 16'h0, 16'h0, 1'b0);
      acc(1'b1, 8'h14, {15'h0, hv[c]}, 16'h0, 1'b0);
      acc(1'b1, 8'h16, m2[c], 16'h0, 1'b0);
      repeat (8) @(posedge clock_in);
      edges(m2[c][15], !hv[c] && m2[c][2] && !m2[c][14], a, b);
      near(a, ec[c]);
      near(b, ed[c]);
    end
    $display("clock path test done");
    acc(1'b1, 8'h16, 16'h0, 16'h0, 1'b0);
    acc(1'b1, 8'h16, 16'h0006, 16'h0, 1'b0);
    for (c = 0; c < 10; c++) begin
      acc(1'b1, 8'h15, {2'h0, c[3:0], 10'h005}, 16'h0, 1'b0);
      gap(0, rt[c] * 4);
    end
    acc(1'b1, 8'h15, 16'h0c05, 16'h0, 1'b0);
    gap(1, 8);
    gap(2, 16);
    acc(1'b1, 8'h0a, 16'h0, 16'h0, 1'b0);
    acc(1'b1, 8'h21, 16'h0040, 16'h0, 1'b0);
    gap(1, 16);
    gap(2, 8);
    $display("strobe test done");
    acc(1'b1, 8'h16, 16'h0004, 16'h0, 1'b0);
    @(posedge clock_in) run <= 1'b0;
    repeat (110) @(posedge clock_in);
    #1;
    chk({15'h0, pres}, 16'h0);
    acc(1'b1, 8'h15, 16'h0c01, 16'h0, 1'b1);
    acc(1'b0, 8'h15, 16'h0, 16'h0, 1'b1);
    acc(1'b0, 8'h16, 16'h0, 16'h0004, 1'b0);
    acc(1'b1, 8'h16, 16'h0, 16'h0, 1'b0);
    acc(1'b0, 8'h15, 16'h0, 16'h0c05, 1'b0);
    @(posedge clock_in) run <= 1'b1;
    $display("access test done");
    end_sim();
  end
endmodule
